//--- src/its_params.svh
`ifndef ITS_PARAMS_SVH
`define ITS_PARAMS_SVH
// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define ITS_NODES       64
`define ITS_CHANS       8
`define ITS_TRAPS       8
`define ITS_EXT_CH      4
`define ITS_SHARED_BASE 60
// ---------------------------------------------------------------
// Timing (clock 10 MHz, response time given in CPU clocks)
// ---------------------------------------------------------------
`define ITS_CLK_MHZ     10
`define ITS_LAT_JC      7
`define ITS_LAT_NJC     11
`define ITS_LAT_JC_LD   4'((`ITS_LAT_JC) - 2)
`define ITS_LAT_NJC_LD  4'((`ITS_LAT_NJC) - 2)
// ---------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------
`define ITS_A_NODE      7'h00
`define ITS_A_CNT       7'h40
`define ITS_A_SRC       7'h48
`define ITS_A_DST       7'h50
`define ITS_A_CPUPRI    7'h58
`define ITS_A_TFLAG     7'h59
`define ITS_A_SSEL      7'h5a
`define ITS_A_EDGE      7'h5b
`define ITS_A_GATE      7'h5c
`define ITS_A_STAT      7'h5d
// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define ITS_F_EN        6
`define ITS_F_REQ       7
`define ITS_F_ROUTE     8
`define ITS_F_CONT      8
`define ITS_F_BYTE      9
`define ITS_F_SINC      10
`define ITS_F_DINC      11
`define ITS_VEC_NODE    8'h20
`define ITS_RST_WORD    16'h0000
`endif

//--- src/its_pkg.sv
package its_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_XFER, ST_TRAP} its_state_e;
  typedef logic [15:0] its_word_t;
endpackage : its_pkg

//--- src/its_top.sv
// Function
// RULE_01: each node routes to the vectored controller or the transfer engine.
// RULE_02: a standard service branches to the node's own vector.
// RULE_03: a transfer steals exactly one cycle and issues no vector.
// RULE_04: a transfer moves a byte or word, then bumps source and/or destination.
// RULE_05: counter decrements per transfer unless continuous; zero raises an interrupt.
// RULE_06: eight independent transfer channels, each triggered by a node.
// RULE_07: request to service start takes 7 or 11 clocks, by jump cache.
// RULE_08: 64 nodes, each with request flag, enable and priority.
// RULE_09: four shared nodes pick their source by a select register.
// RULE_10: external router has four input channels with edge logic.
// RULE_11: each edge channel detects rising, falling or both edges.
// RULE_12: gating units pass events on pattern match or pattern miss.
// RULE_13: a hardware trap branches at once to its own vector.
// RULE_14: each trap sets its own bit in the trap flag register.
// RULE_15: a trap preempts everything except a higher trap in service; here an equal trap in service and a transfer cycle also hold it off.
// RULE_16: during a trap service interrupts and transfers wait.
// RULE_17: three service request pins feed system request zero and one.
// RULE_18: the software trap enters the service named by its number.
// RULE_19: software setting a request flag acts like a hardware request.
// RULE_20: highest enabled priority above CPU level wins; flag clears at start.
// RULE_21: a transfer clears its node flag unless it escalates.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "its_params.svh"
module its_top
  import its_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [6:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Request sources
  input  wire logic [59:0] node_src,
  input  wire logic [11:0] shared_src,
  input  wire logic [3:0]  ext_in,
  input  wire logic [2:0]  svc_req_pin,
  input  wire logic [5:0]  hw_trap,
  // CPU side
  input  wire logic        jump_cache_hit,
  input  wire logic        sw_trap,
  input  wire logic [7:0]  sw_trap_num,
  input  wire logic        trap_done,
  output logic             svc_take,
  output logic      [7:0]  svc_vector,
  output logic             trap_active,
  output logic             xfer_req,
  output logic      [15:0] xfer_src,
  output logic      [15:0] xfer_dst,
  output logic             xfer_byte
);
  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  its_state_e  st;
  logic [63:0] node_flag;
  logic [63:0] node_en;
  logic [63:0] node_route;
  logic [3:0]  node_pri  [64];
  logic [2:0]  node_chan [64];
  logic [7:0]  ch_cnt    [8];
  logic [7:0]  ch_cont;
  logic [7:0]  ch_byte;
  logic [7:0]  ch_sinc;
  logic [7:0]  ch_dinc;
  its_word_t   ch_src    [8];
  its_word_t   ch_dst    [8];
  logic [3:0]  cpu_pri;
  logic [7:0]  trap_flags;
  logic [7:0]  trap_pend;
  logic [2:0]  cur_trap;
  logic [7:0]  sel_reg;
  logic [7:0]  edge_mode;
  logic [11:0] gate_cfg;
  logic [3:0]  ext_prev;
  logic [2:0]  svc_req_prev;
  logic [5:0]  cur_node;
  logic [2:0]  cur_ch;
  logic [3:0]  lat;

  // -------------------------------------------------------------
  // External request router
  // -------------------------------------------------------------
  wire [3:0] ext_rise = ext_in & ~ext_prev;
  wire [3:0] ext_fall = ~ext_in & ext_prev;
  logic [3:0] ext_ev;
  logic [3:0] gate_out;
  logic [3:0] shared_pick;
  for (genvar i = 0; i < `ITS_EXT_CH; i++) begin : g_ext
    wire [1:0] md   = edge_mode[2*i +: 2];
    wire       hit  = (ext_in == gate_cfg[3:0]);
    wire [3:0] cand = {shared_src[3*i +: 3], gate_out[i]};
    assign ext_ev[i]      = (md[0] & ext_rise[i]) | (md[1] & ext_fall[i]); // RULE_10 RULE_11
    assign gate_out[i]    = ext_ev[i] & gate_cfg[4+i] & (hit ^ gate_cfg[8+i]); // RULE_12
    assign shared_pick[i] = cand[sel_reg[2*i +: 2]]; // RULE_09
  end

  // -------------------------------------------------------------
  // Arbitration
  // -------------------------------------------------------------
  logic       win_valid;
  logic [5:0] win_node;
  logic [3:0] win_pri;
  always_comb begin
    win_valid = 1'b0;
    win_node  = 6'h00;
    win_pri   = cpu_pri;
    for (int n = 0; n < `ITS_NODES; n++) begin
      if (node_flag[n] && node_en[n] && node_pri[n] > win_pri) begin // RULE_20
        win_valid = 1'b1;
        win_node  = 6'(n);
        win_pri   = node_pri[n];
      end
    end
  end

  // -------------------------------------------------------------
  // Traps
  // -------------------------------------------------------------
  wire       sys_req0_ev = svc_req_pin[0] & ~svc_req_prev[0];
  wire       sys_req1_ev = |(svc_req_pin[2:1] & ~svc_req_prev[2:1]);
  wire [7:0] trap_ev     = {hw_trap, sys_req1_ev, sys_req0_ev}; // RULE_17
  logic [2:0] top_trap;
  always_comb begin
    top_trap = 3'h0;
    for (int t = 0; t < `ITS_TRAPS; t++) begin
      if (trap_pend[t]) begin
        top_trap = 3'(t);
      end
    end
  end
  wire trap_go = (|trap_pend) && (st != ST_XFER) &&
                 (!trap_active || top_trap > cur_trap); // RULE_15

  // -------------------------------------------------------------
  // Sequencing decode
  // -------------------------------------------------------------
  wire        sel_route = node_route[cur_node];
  wire [2:0]  sel_ch    = node_chan[cur_node];
  wire        issue     = (st == ST_WAIT) && (lat == 4'h0) && !trap_go;
  wire        go_xfer   = issue && sel_route &&
                          (ch_cont[sel_ch] || ch_cnt[sel_ch] != 8'h00); // RULE_01
  wire        go_int    = issue && !go_xfer;
  wire        go_sw     = (st == ST_IDLE) && sw_trap && !trap_go;
  wire        go_wait   = (st == ST_IDLE) && win_valid && !trap_go && !sw_trap;
  wire [7:0]  cnt_next  = ch_cnt[cur_ch] - 8'h01;
  wire        escalate  = !ch_cont[cur_ch] && cnt_next == 8'h00;
  wire        clr_int   = ce && go_int;
  wire        clr_xfer  = ce && (st == ST_XFER) && !escalate; // RULE_21
  wire [15:0] step      = ch_byte[cur_ch] ? 16'h0001 : 16'h0002;

  assign xfer_req  = (st == ST_XFER); // RULE_03
  assign xfer_src  = ch_src[cur_ch];
  assign xfer_dst  = ch_dst[cur_ch];
  assign xfer_byte = ch_byte[cur_ch];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= ST_IDLE;
      lat         <= 4'h0;
      cur_node    <= 6'h00;
      cur_ch      <= 3'h0;
      cur_trap    <= 3'h0;
      svc_take    <= 1'b0;
      svc_vector  <= 8'h00;
      trap_active <= 1'b0;
    end else if (ce) begin
      svc_take <= 1'b0;
      if (trap_go) begin
        st          <= ST_TRAP; // RULE_13 RULE_15
        cur_trap    <= top_trap;
        trap_active <= 1'b1;
        svc_take    <= 1'b1;
        svc_vector  <= {5'h00, top_trap};
      end else begin
        unique case (st)
          ST_IDLE: begin
            if (go_sw) begin
              svc_take   <= 1'b1; // RULE_18
              svc_vector <= sw_trap_num;
            end else if (go_wait) begin
              st       <= ST_WAIT; // RULE_07
              cur_node <= win_node;
              lat      <= jump_cache_hit ? `ITS_LAT_JC_LD : `ITS_LAT_NJC_LD;
            end
          end
          ST_WAIT: begin
            if (lat != 4'h0) begin
              lat <= lat - 4'h1;
            end else if (go_xfer) begin
              st     <= ST_XFER;
              cur_ch <= sel_ch;
            end else begin
              st         <= ST_IDLE; // RULE_02
              svc_take   <= 1'b1;
              svc_vector <= `ITS_VEC_NODE + {2'b00, cur_node};
            end
          end
          ST_XFER: st <= ST_IDLE;
          ST_TRAP: begin
            if (trap_done) begin
              st          <= ST_IDLE; // RULE_16
              trap_active <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // Per-node control and request flags
  // -------------------------------------------------------------
  for (genvar n = 0; n < `ITS_NODES; n++) begin : g_node
    wire wr_n = reg_wr && reg_addr == 7'(`ITS_A_NODE + n);
    wire clr_n = (clr_int || clr_xfer) && cur_node == 6'(n);
    wire src_n;
    if (n < `ITS_SHARED_BASE) begin : g_ded
      assign src_n = node_src[n];
    end else begin : g_shr
      assign src_n = shared_pick[n - `ITS_SHARED_BASE];
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        node_flag[n]  <= 1'b0;
        node_en[n]    <= 1'b0;
        node_route[n] <= 1'b0;
        node_pri[n]   <= 4'h0;
        node_chan[n]  <= 3'h0;
      end else if (ce) begin
        // A source pulse wins over any clear in the same cycle
        node_flag[n] <= src_n | (wr_n ? reg_wdata[`ITS_F_REQ] : (node_flag[n] & ~clr_n)); // RULE_19 RULE_20
        if (wr_n) begin
          node_en[n]    <= reg_wdata[`ITS_F_EN]; // RULE_08
          node_route[n] <= reg_wdata[`ITS_F_ROUTE];
          node_pri[n]   <= reg_wdata[3:0];
          node_chan[n]  <= reg_wdata[11:9];
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Transfer channels
  // -------------------------------------------------------------
  for (genvar c = 0; c < `ITS_CHANS; c++) begin : g_chan
    wire wr_c = reg_wr && reg_addr == 7'(`ITS_A_CNT + c);
    wire wr_s = reg_wr && reg_addr == 7'(`ITS_A_SRC + c);
    wire wr_d = reg_wr && reg_addr == 7'(`ITS_A_DST + c);
    wire upd  = xfer_req && cur_ch == 3'(c);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ch_cnt[c]  <= 8'h00;
        ch_cont[c] <= 1'b0;
        ch_byte[c] <= 1'b0;
        ch_sinc[c] <= 1'b0;
        ch_dinc[c] <= 1'b0;
        ch_src[c]  <= `ITS_RST_WORD;
        ch_dst[c]  <= `ITS_RST_WORD;
      end else if (ce) begin
        // The completing transfer owns the channel over a bus write
        if (upd) begin
          if (!ch_cont[c]) begin
            ch_cnt[c] <= cnt_next; // RULE_05
          end
          if (ch_sinc[c]) begin
            ch_src[c] <= ch_src[c] + step; // RULE_04
          end
          if (ch_dinc[c]) begin
            ch_dst[c] <= ch_dst[c] + step; // RULE_04
          end
        end else begin
          if (wr_c) begin
            ch_cnt[c]  <= reg_wdata[7:0]; // RULE_06
            ch_cont[c] <= reg_wdata[`ITS_F_CONT];
            ch_byte[c] <= reg_wdata[`ITS_F_BYTE];
            ch_sinc[c] <= reg_wdata[`ITS_F_SINC];
            ch_dinc[c] <= reg_wdata[`ITS_F_DINC];
          end
          if (wr_s) begin
            ch_src[c] <= reg_wdata;
          end
          if (wr_d) begin
            ch_dst[c] <= reg_wdata;
          end
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Global registers, trap flags, edge history
  // -------------------------------------------------------------
  wire wr_tflag = reg_wr && reg_addr == `ITS_A_TFLAG;
  wire [7:0] trap_take_mask = trap_go ? (8'h01 << top_trap) : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_pri      <= 4'h0;
      trap_flags   <= 8'h00;
      trap_pend    <= 8'h00;
      sel_reg      <= 8'h00;
      edge_mode    <= 8'h00;
      gate_cfg     <= 12'h000;
      ext_prev     <= 4'h0;
      svc_req_prev <= 3'h0;
    end else if (ce) begin
      ext_prev     <= ext_in;
      svc_req_prev <= svc_req_pin;
      // Write one to clear; a new trap in that cycle stays flagged
      trap_flags   <= trap_ev | (trap_flags & ~(wr_tflag ? reg_wdata[7:0] : 8'h00)); // RULE_14
      trap_pend <= trap_ev | (trap_pend & ~trap_take_mask);
      if (reg_wr && reg_addr == `ITS_A_CPUPRI) cpu_pri   <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `ITS_A_SSEL)   sel_reg   <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `ITS_A_EDGE)   edge_mode <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `ITS_A_GATE)   gate_cfg  <= reg_wdata[11:0];
    end
  end

  // -------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------
  wire [5:0]  ra_node = reg_addr[5:0];
  wire [2:0]  ra_ch   = reg_addr[2:0];
  wire [15:0] node_rd = {4'h0, node_chan[ra_node], node_route[ra_node],
                         node_flag[ra_node], node_en[ra_node], 2'b00, node_pri[ra_node]};
  wire [15:0] cnt_rd  = {4'h0, ch_dinc[ra_ch], ch_sinc[ra_ch], ch_byte[ra_ch],
                         ch_cont[ra_ch], ch_cnt[ra_ch]};
  wire [15:0] stat_rd = {4'h0, st, trap_active, win_valid, cur_trap, 2'b00, cur_ch};
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (reg_addr < `ITS_A_CNT) rd_val = node_rd;
    else if (reg_addr < `ITS_A_SRC) rd_val = cnt_rd;
    else if (reg_addr < `ITS_A_DST) rd_val = ch_src[ra_ch];
    else if (reg_addr < `ITS_A_CPUPRI) rd_val = ch_dst[ra_ch];
    else if (reg_addr == `ITS_A_CPUPRI) rd_val = {12'h000, cpu_pri};
    else if (reg_addr == `ITS_A_TFLAG) rd_val = {8'h00, trap_flags};
    else if (reg_addr == `ITS_A_SSEL) rd_val = {8'h00, sel_reg};
    else if (reg_addr == `ITS_A_EDGE) rd_val = {8'h00, edge_mode};
    else if (reg_addr == `ITS_A_GATE) rd_val = {4'h0, gate_cfg};
    else if (reg_addr == `ITS_A_STAT) rd_val = stat_rd;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_val : 16'h0000;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] wait_len;
  logic       wait_njc;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_len <= 4'h0;
      wait_njc <= 1'b0;
    end else if (ce) begin
      wait_len <= (st == ST_WAIT) ? wait_len + 4'h1 : 4'h0;
      if (go_wait) wait_njc <= !jump_cache_hit;
    end
  end

  a_xfer_one_cycle: assert property (xfer_req && ce |=> !xfer_req) // RULE_03
    else $error("transfer held more than one cycle");
  a_xfer_no_vec: assert property (xfer_req |-> !svc_take) // RULE_03
    else $error("transfer issued a vector");
  a_lat_jc: assert property ((ce && go_wait && jump_cache_hit) ##1 // RULE_07
      (ce && st == ST_WAIT)[*6] |=> (svc_take || xfer_req))
    else $error("service did not start after 7 clocks");
  a_lat_njc: assert property ((ce && st == ST_WAIT && wait_njc && wait_len == 4'h9) // RULE_07
      |=> (svc_take || xfer_req))
    else $error("service did not start after 11 clocks");
  a_trap_entry: assert property ($rose(trap_active) |-> svc_take && svc_vector < 8'h08) // RULE_13
    else $error("trap entry without its vector");
  a_trap_flag: assert property (ce && trap_ev[0] |=> trap_flags[0]) // RULE_14
    else $error("trap flag not set");
  a_trap_holds: assert property (ce && st == ST_TRAP && !trap_done |=> st == ST_TRAP && !xfer_req) // RULE_16
    else $error("trap service left early");
  a_sw_request: assert property (ce && reg_wr && reg_addr < `ITS_A_CNT && reg_wdata[`ITS_F_REQ] // RULE_19
      |=> node_flag[$past(ra_node)])
    else $error("software request flag not set");
  a_cnt_dec: assert property (ce && xfer_req && !ch_cont[cur_ch] // RULE_05
      |=> ch_cnt[$past(cur_ch)] == $past(ch_cnt[cur_ch]) - 8'h01)
    else $error("transfer counter not decremented");
  a_edge_rise: assert property (edge_mode[1:0] == 2'b01 && ext_in[0] && !ext_prev[0] |-> ext_ev[0]) // RULE_11
    else $error("rising edge missed");
endmodule : its_top
`default_nettype wire

//--- verif/its_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module its_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench control
  input  wire logic use_jc,
  input  wire logic release_trap,
  // Controller side
  input  wire logic trap_active,
  output logic      jump_cache_hit,
  output logic      trap_done
);
  assign jump_cache_hit = use_jc;
  // Return is a single pulse with a gap after it, so one return never counts twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      trap_done <= 1'b0;
    else
      trap_done <= release_trap && trap_active && !trap_done;
  end
endmodule : its_cpu_model
`default_nettype wire

//--- verif/its_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module its_top_test;
  import its_pkg::*;
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk, rst_n, ce, reg_wr, reg_rd, use_jc, release_trap, sw_trap;
  logic        jump_cache_hit, trap_done, svc_take, trap_active, xfer_req, xfer_byte;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, xfer_src, xfer_dst;
  logic [59:0] node_src;
  logic [11:0] shared_src;
  logic [3:0]  ext_in;
  logic [2:0]  svc_req_pin;
  logic [5:0]  hw_trap;
  logic [7:0]  sw_trap_num, svc_vector;
  int          errors, n_compared, cycles;

  its_top its_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .node_src(node_src), .shared_src(shared_src),
    .ext_in(ext_in), .svc_req_pin(svc_req_pin), .hw_trap(hw_trap), .jump_cache_hit(jump_cache_hit),
    .sw_trap(sw_trap), .sw_trap_num(sw_trap_num), .trap_done(trap_done), .svc_take(svc_take),
    .svc_vector(svc_vector), .trap_active(trap_active), .xfer_req(xfer_req), .xfer_src(xfer_src),
    .xfer_dst(xfer_dst), .xfer_byte(xfer_byte));
  its_cpu_model its_cpu_model_i (.clk(clk), .rst_n(rst_n), .use_jc(use_jc), .release_trap(release_trap),
    .trap_active(trap_active), .jump_cache_hit(jump_cache_hit), .trap_done(trap_done));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [6:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(what, exp, reg_rdata)
  endtask : rd

  // Kind 0 node, 1 hardware trap, 2 shared source, 3 software trap
  task pulse(input int k, input int i);
    @(posedge clk);
    case (k)
      0: node_src[i] <= 1'b1;
      1: hw_trap[i] <= 1'b1;
      2: shared_src[i] <= 1'b1;
      default: sw_trap <= 1'b1;
    endcase
    @(posedge clk);
    node_src   <= '0;
    hw_trap    <= '0;
    shared_src <= '0;
    sw_trap    <= 1'b0;
  endtask : pulse

  // Counts edges until a service start or a stolen cycle; exp_n below 0 skips the count
  task wait_ev(input logic xf, input int exp_n, input logic [7:0] vec, input string what);
    int n;
    n = 0;
    #1;
    while (((xf ? xfer_req : svc_take) !== 1'b1) && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (exp_n >= 0) `CHK(what, exp_n, n)
    `CHK(what, 1'b1, (xf ? xfer_req : svc_take))
    if (!xf) `CHK(what, vec, svc_vector)
  endtask : wait_ev

  task quiet(input int cyc, input string what);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (svc_take === 1'b1) hits++;
    end
    `CHK(what, 0, hits)
  endtask : quiet

  task end_of_test;
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Clock, reset, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, sw_trap, release_trap, reg_addr, reg_wdata} = '0;
    {node_src, shared_src, ext_in, svc_req_pin, hw_trap} = '0;
    ce = 1'b1;
    use_jc = 1'b1;
    sw_trap_num = 8'h33;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(7'h00, 16'h0000, "node0 reset");
    rd(7'h7f, 16'h0000, "unmapped");
    @(posedge clk);
    #1 `CHK("rdata one cycle", 16'h0000, reg_rdata)
    // Priority against CPU level, software-set flags
    wr(7'h58, 16'h0003);
    wr(7'h03, 16'h00c2);
    wr(7'h09, 16'h00c5);
    wait_ev(1'b0, 7, 8'h29, "prio winner");
    quiet(20, "below cpu prio");
    rd(7'h09, 16'h0045, "flag cleared");
    wr(7'h58, 16'h0000);
    wait_ev(1'b0, -1, 8'h23, "lower prio later");
    use_jc <= 1'b0;
    wr(7'h05, 16'h00c3);
    wait_ev(1'b0, 11, 8'h25, "latency no cache");
    use_jc <= 1'b1;
    // Word transfer on channel 2, both pointers, counting down
    wr(7'h42, 16'h0c02);
    wr(7'h4a, 16'h1000);
    wr(7'h52, 16'h2000);
    wr(7'h0a, 16'h0541);
    pulse(0, 10);
    wait_ev(1'b1, 7, 8'h00, "xfer latency");
    `CHK("xfer src", 16'h1000, xfer_src)
    `CHK("xfer dst", 16'h2000, xfer_dst)
    `CHK("xfer word", 1'b0, xfer_byte)
    `CHK("no vector", 1'b0, svc_take)
    @(posedge clk);
    #1 `CHK("one stolen cycle", 1'b0, xfer_req)
    rd(7'h4a, 16'h1002, "src step");
    rd(7'h52, 16'h2002, "dst step");
    rd(7'h42, 16'h0c01, "count dec");
    rd(7'h0a, 16'h0541, "xfer flag clear");
    pulse(0, 10);
    wait_ev(1'b1, 7, 8'h00, "last xfer");
    wait_ev(1'b0, -1, 8'h2a, "count zero irq");
    rd(7'h42, 16'h0c00, "count zero");
    // Byte transfer on channel 1, continuous, source only
    wr(7'h41, 16'h0705);
    wr(7'h49, 16'h0300);
    wr(7'h51, 16'h0400);
    wr(7'h0b, 16'h0341);
    pulse(0, 11);
    wait_ev(1'b1, 7, 8'h00, "byte xfer");
    `CHK("xfer byte", 1'b1, xfer_byte)
    rd(7'h49, 16'h0301, "src byte step");
    rd(7'h51, 16'h0400, "dst kept");
    rd(7'h41, 16'h0705, "continuous count");
    // Router: rising only, then falling with pattern miss
    wr(7'h5b, 16'h0001);
    wr(7'h5c, 16'h0011);
    wr(7'h3c, 16'h0041);
    @(posedge clk);
    ext_in <= 4'h1;
    wait_ev(1'b0, -1, 8'h5c, "rise event");
    @(posedge clk);
    ext_in <= 4'h0;
    quiet(20, "fall ignored");
    wr(7'h5b, 16'h0002);
    wr(7'h5c, 16'h0111);
    @(posedge clk);
    ext_in <= 4'h1;
    quiet(20, "rise ignored");
    @(posedge clk);
    ext_in <= 4'h0;
    wait_ev(1'b0, -1, 8'h5c, "fall on miss");
    // Shared node 61 fed by shared source 3
    wr(7'h5a, 16'h0004);
    wr(7'h3d, 16'h0041);
    pulse(2, 3);
    wait_ev(1'b0, -1, 8'h5d, "shared select");
    // Traps: nesting, masking of interrupts, flag register
    pulse(1, 3);
    wait_ev(1'b0, 1, 8'h05, "trap take");
    `CHK("trap active", 1'b1, trap_active)
    wr(7'h05, 16'h00c3);
    quiet(20, "irq held in trap");
    pulse(1, 1);
    quiet(10, "lower trap held");
    pulse(1, 5);
    wait_ev(1'b0, 1, 8'h07, "higher trap");
    rd(7'h59, 16'h00a8, "trap flags");
    release_trap <= 1'b1;
    repeat (60) @(posedge clk);
    release_trap <= 1'b0;
    wr(7'h59, 16'h00ff);
    rd(7'h59, 16'h0000, "flags cleared");
    @(posedge clk);
    svc_req_pin <= 3'b101;
    repeat (10) @(posedge clk);
    rd(7'h59, 16'h0003, "service pins");
    release_trap <= 1'b1;
    repeat (40) @(posedge clk);
    release_trap <= 1'b0;
    // Enable low freezes a pending request before its latency count starts
    wr(7'h07, 16'h00c1);
    ce <= 1'b0;
    quiet(10, "frozen by enable");
    @(posedge clk);
    ce <= 1'b1;
    wait_ev(1'b0, 7, 8'h27, "resume after enable");
    pulse(3, 0);
    wait_ev(1'b0, 0, 8'h33, "software trap");
    end_of_test();
  end
endmodule : its_top_test
`default_nettype wire
